// ===== include/dma_pkg.sv
package dma_pkg;

	// Channel count
	localparam int NUM_CH = 2;

	// Bus byte addresses (low twelve bits of haddr)
	localparam logic [11:0] CTL0_ADDR = 12'hFB0;
	localparam logic [11:0] CTL1_ADDR = 12'hFB8;
	localparam logic [11:0] IO0_ADDR  = 12'hFC0;
	localparam logic [11:0] SA0_ADDR  = 12'hFC4;
	localparam logic [11:0] EA0_ADDR  = 12'hFC8;
	localparam logic [11:0] IO1_ADDR  = 12'hFD0;
	localparam logic [11:0] SA1_ADDR  = 12'hFD4;
	localparam logic [11:0] EA1_ADDR  = 12'hFD8;
	localparam logic [11:0] STS_ADDR  = 12'hFE0;
	localparam logic [11:0] MSK_ADDR  = 12'hFE4;

	// Field positions of the control register
	localparam int EN_POS   = 7;
	localparam int LOOP_POS = 6;
	localparam int DIR_POS  = 5;
	localparam int IRQ_POS  = 4;
	localparam int WORD_POS = 3;
	localparam int SRC_LSB  = 0;

	// Reset values
	localparam logic [7:0]  CTL_RST  = 8'h00;
	localparam logic [7:0]  IO_RST   = 8'h00;
	localparam logic [11:0] ADDR_RST = 12'h000;
	localparam logic [1:0]  FLAG_RST = 2'h0;

	// Peripheral page, reserved trigger code and address steps
	localparam logic [3:0]  PERIPH_PAGE = 4'hF;
	localparam logic [2:0]  TRIG_RSVD   = 3'h7;
	localparam logic [11:0] BYTE_STEP   = 12'h001;
	localparam logic [11:0] WORD_STEP   = 12'h002;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       en;
		logic       loop;
		logic       dir;
		logic       completion_interrupt_enable;
		logic       word;
		logic [2:0] src;
	} ctl_t;

	// One channel's programmed and running state
	typedef struct packed {
		ctl_t        ctl;
		logic [7:0]  io;
		logic [11:0] start;
		logic [11:0] end_a;
		logic [11:0] cur;
		logic        pend;
	} chan_t;

	// Transfer sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_REQ  = 4'b0010,
		ST_RD   = 4'b0100,
		ST_WR   = 4'b1000
	} fsm_t;

	// System bus outputs travel together
	typedef struct packed {
		logic        req;
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} sbus_out_t;

endpackage

// ===== core/dma_ctrl.sv
// Operation
// [RQ1] Disabled channel ignores requests, moves nothing
// [RQ2] Enabled channel transfers once per trigger request
// [RQ3] Single pass: end reloads start, clears enable
// [RQ4] Loop mode: end reloads start, stays enabled
// [RQ5] Direction bit picks source and destination path
// [RQ6] Interrupt enable raises request after end transfer
// [RQ7] Byte mode moves one byte per request
// [RQ8] Word mode moves two bytes per request
// [RQ9] Software gives even peripheral address for words
// [RQ10] Codes zero to three pick timers; seven reserved
// [RQ11] Codes four to six pick serial events
// [RQ12] Triggers work regardless of central interrupt enables
// [RQ13] Software enables request inside the trigger source
// [RQ14] Request bus, await acknowledge, move, release
// [RQ15] Not at end: advance address by step
// [RQ16] Completion found by comparing current with end
// [RQ17] Peripheral address is page F plus byte
// [RQ18] Trigger during pending transfer held once
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module dma_ctrl (
	input  wire logic                         hclk,
	input  wire logic                         hresetn,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic                              hreadyout,
	output logic [31:0]                       hrdata,
	output logic                              hresp,
	input  wire logic [1:0][6:0]              trig,
	input  wire logic                         sbus_ack,
	input  wire logic [7:0]                   sbus_rdata,
	output dma_pkg::sbus_out_t                sbus,
	output logic                              irq
);

	// Whole block state
	typedef struct packed {
		dma_pkg::chan_t [1:0] ch;       // Both channels
		logic [1:0]           sts;      // Sticky end flags
		logic [1:0]           msk;      // Interrupt masks
		dma_pkg::fsm_t        fsm;      // Sequencer state
		logic                 act;      // Channel being served
		logic                 idx;      // Byte within word
		logic                 a_wr;     // Write data phase pending
		logic                 a_rd;     // Read wait state pending
		logic [11:0]          a_addr;   // Latched bus address
		logic                 hready;   // Ready output
		logic [31:0]          hrdata;   // Read data output
		dma_pkg::sbus_out_t   sb;       // System bus outputs
		logic                 irq;      // Interrupt output
	} state_t;

	state_t s_r;     // Registered state
	state_t s_nxt;   // Next state

	// Selected trigger of one channel; reserved code never fires
	function automatic logic trig_pick(input logic [6:0] t, input logic [2:0] sel);
		logic hit;
		hit = 1'b0;
		if (sel != dma_pkg::TRIG_RSVD)
			hit = t[sel]; // [RQ10] [RQ11] [RQ12]
		return hit;
	endfunction

	// Register file or peripheral address for a byte
	function automatic logic [11:0] addr_of(input dma_pkg::chan_t c, input logic i,
		input logic periph);
		logic [11:0] a;
		a = 12'(c.cur + 12'(i));
		if (periph)
			a = {dma_pkg::PERIPH_PAGE, 8'(c.io + 8'(i))}; // [RQ17] [RQ9]
		return a;
	endfunction

	// Read value of a mapped register, zero elsewhere
	function automatic logic [31:0] rd_word(input state_t s, input logic [11:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			dma_pkg::CTL0_ADDR: d = {24'h00_0000, s.ch[0].ctl};
			dma_pkg::CTL1_ADDR: d = {24'h00_0000, s.ch[1].ctl};
			dma_pkg::IO0_ADDR:  d = {24'h00_0000, s.ch[0].io};
			dma_pkg::IO1_ADDR:  d = {24'h00_0000, s.ch[1].io};
			dma_pkg::SA0_ADDR:  d = {4'h0, s.ch[0].start, 4'h0, s.ch[0].cur};
			dma_pkg::SA1_ADDR:  d = {4'h0, s.ch[1].start, 4'h0, s.ch[1].cur};
			dma_pkg::EA0_ADDR:  d = {20'h0_0000, s.ch[0].end_a};
			dma_pkg::EA1_ADDR:  d = {20'h0_0000, s.ch[1].end_a};
			dma_pkg::STS_ADDR:  d = {30'h0000_0000, s.sts};
			dma_pkg::MSK_ADDR:  d = {30'h0000_0000, s.msk};
			default:            d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	// Register map addresses per channel
	localparam logic [1:0][11:0] CTL_A = {dma_pkg::CTL1_ADDR, dma_pkg::CTL0_ADDR};
	localparam logic [1:0][11:0] IO_A  = {dma_pkg::IO1_ADDR, dma_pkg::IO0_ADDR};
	localparam logic [1:0][11:0] SA_A  = {dma_pkg::SA1_ADDR, dma_pkg::SA0_ADDR};
	localparam logic [1:0][11:0] EA_A  = {dma_pkg::EA1_ADDR, dma_pkg::EA0_ADDR};

	dma_pkg::chan_t cur_c;   // Channel under service
	logic           last_b;  // Final byte of this request
	logic           at_end;  // Current address equals end

	assign cur_c  = s_r.ch[s_r.act];
	assign last_b = !(cur_c.ctl.word && !s_r.idx); // [RQ7] [RQ8]
	assign at_end = (cur_c.cur == cur_c.end_a); // [RQ16]

	// Next-state logic: bus slave, sequencer, triggers, interrupt
	always_comb
	begin
		s_nxt = s_r;

		// Bus write data phase
		if (s_r.a_wr)
		begin
			s_nxt.a_wr = 1'b0;
			for (int i = 0; i < dma_pkg::NUM_CH; i++)
			begin
				if (s_r.a_addr == CTL_A[i])
					s_nxt.ch[i].ctl = hwdata[7:0];
				if (s_r.a_addr == IO_A[i])
					s_nxt.ch[i].io = hwdata[7:0];
				if (s_r.a_addr == SA_A[i])
				begin
					// Start write also resets the running address
					s_nxt.ch[i].start = hwdata[11:0];
					s_nxt.ch[i].cur   = hwdata[11:0];
				end
				if (s_r.a_addr == EA_A[i])
					s_nxt.ch[i].end_a = hwdata[11:0];
			end
			if (s_r.a_addr == dma_pkg::STS_ADDR)
				s_nxt.sts = s_r.sts & ~hwdata[1:0];
			if (s_r.a_addr == dma_pkg::MSK_ADDR)
				s_nxt.msk = hwdata[1:0];
		end

		// Read wait state ends with data registered
		if (s_r.a_rd)
		begin
			s_nxt.a_rd   = 1'b0;
			s_nxt.hrdata = rd_word(s_r, s_r.a_addr);
			s_nxt.hready = 1'b1;
		end

		// Bus address phase
		if (hsel && hready && htrans[1])
		begin
			s_nxt.a_addr = haddr[11:0];
			s_nxt.a_wr   = hwrite;
			s_nxt.a_rd   = !hwrite;
			s_nxt.hready = hwrite;
		end

		// Transfer sequencer
		unique case (s_r.fsm)
			dma_pkg::ST_IDLE:
			begin
				if (s_r.ch[0].pend || s_r.ch[1].pend)
				begin
					// First channel wins a tie
					s_nxt.act = !s_r.ch[0].pend;
					s_nxt.ch[!s_r.ch[0].pend].pend = 1'b0;
					s_nxt.idx    = 1'b0;
					s_nxt.sb.req = 1'b1; // [RQ14]
					s_nxt.fsm    = dma_pkg::ST_REQ;
				end
			end
			dma_pkg::ST_REQ:
			begin
				// Hold the request until the processor yields
				if (sbus_ack)
				begin
					s_nxt.sb.rd   = 1'b1; // [RQ14]
					s_nxt.sb.addr = addr_of(cur_c, s_r.idx, cur_c.ctl.dir); // [RQ5]
					s_nxt.fsm     = dma_pkg::ST_RD;
				end
			end
			dma_pkg::ST_RD:
			begin
				// Read data is taken at the end of the strobe cycle
				s_nxt.sb.rd    = 1'b0;
				s_nxt.sb.wr    = 1'b1;
				s_nxt.sb.wdata = sbus_rdata;
				s_nxt.sb.addr  = addr_of(cur_c, s_r.idx, !cur_c.ctl.dir); // [RQ5]
				s_nxt.fsm      = dma_pkg::ST_WR;
			end
			dma_pkg::ST_WR:
			begin
				s_nxt.sb.wr = 1'b0;
				if (!last_b)
				begin
					// Second byte of a word
					s_nxt.idx     = 1'b1; // [RQ8]
					s_nxt.sb.rd   = 1'b1;
					s_nxt.sb.addr = addr_of(cur_c, 1'b1, cur_c.ctl.dir);
					s_nxt.fsm     = dma_pkg::ST_RD;
				end
				else
				begin
					// Done: hand the bus back and update addresses
					s_nxt.sb.req = 1'b0; // [RQ14]
					s_nxt.fsm    = dma_pkg::ST_IDLE;
					if (at_end)
					begin
						s_nxt.ch[s_r.act].cur = cur_c.start; // [RQ3] [RQ4]
						if (!cur_c.ctl.loop)
							s_nxt.ch[s_r.act].ctl.en = 1'b0; // [RQ3]
						if (cur_c.ctl.completion_interrupt_enable)
							s_nxt.sts[s_r.act] = 1'b1; // [RQ6]
					end
					else
						s_nxt.ch[s_r.act].cur = 12'(cur_c.cur + (cur_c.ctl.word ?
							dma_pkg::WORD_STEP : dma_pkg::BYTE_STEP)); // [RQ15]
				end
			end
		endcase

		// Trigger capture; a set wins over the take above
		for (int i = 0; i < dma_pkg::NUM_CH; i++)
		begin
			if (trig_pick(trig[i], s_r.ch[i].ctl.src))
				s_nxt.ch[i].pend = 1'b1; // [RQ2] [RQ18]
			if (!s_r.ch[i].ctl.en)
				s_nxt.ch[i].pend = 1'b0; // [RQ1]
		end

		// Level interrupt from unmasked flags
		s_nxt.irq = |(s_nxt.sts & s_nxt.msk); // [RQ6]
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < dma_pkg::NUM_CH; i++)
			begin
				s_r.ch[i].ctl   <= dma_pkg::CTL_RST;
				s_r.ch[i].io    <= dma_pkg::IO_RST;
				s_r.ch[i].start <= dma_pkg::ADDR_RST;
				s_r.ch[i].end_a <= dma_pkg::ADDR_RST;
				s_r.ch[i].cur   <= dma_pkg::ADDR_RST;
				s_r.ch[i].pend  <= 1'b0;
			end
			s_r.sts    <= dma_pkg::FLAG_RST;
			s_r.msk    <= dma_pkg::FLAG_RST;
			s_r.fsm    <= dma_pkg::ST_IDLE;
			s_r.act    <= 1'b0;
			s_r.idx    <= 1'b0;
			s_r.a_wr   <= 1'b0;
			s_r.a_rd   <= 1'b0;
			s_r.a_addr <= 12'h000;
			s_r.hready <= 1'b1;
			s_r.hrdata <= 32'h0000_0000;
			s_r.sb     <= '0;
			s_r.irq    <= 1'b0;
		end
		else
			s_r <= s_nxt;
	end

	// Outputs straight from the state register, hresp tied to zero
	assign hreadyout = s_r.hready;
	assign hrdata    = s_r.hrdata;
	assign hresp     = 1'b0;
	assign sbus      = s_r.sb;
	assign irq       = s_r.irq;

	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic fin;   // Final write cycle of a request
	assign fin = (s_r.fsm == dma_pkg::ST_WR) && last_b;

	// Per-channel request checks
	for (genvar g = 0; g < dma_pkg::NUM_CH; g++)
	begin : g_chk
		dis_ignore_a: assert property ( // [RQ1]
			!s_r.ch[g].ctl.en |=> !s_r.ch[g].pend)
			else $error("disabled channel kept a request");
		trig_pend_a: assert property ( // [RQ2]
			s_r.ch[g].ctl.en && trig_pick(trig[g], s_r.ch[g].ctl.src)
			|=> s_r.ch[g].pend)
			else $error("enabled trigger was not held");
		rsvd_quiet_a: assert property ( // [RQ10]
			s_r.ch[g].ctl.src == dma_pkg::TRIG_RSVD && !s_r.ch[g].pend |=> !s_r.ch[g].pend)
			else $error("reserved trigger code raised a request");
	end

	// Sequencer and transfer checks
	single_pass_a: assert property ( // [RQ3]
		fin && at_end && !cur_c.ctl.loop && !s_r.a_wr
		|=> !cur_c.ctl.en && cur_c.cur == cur_c.start)
		else $error("single pass end did not stop and reload");
	loop_keep_a: assert property ( // [RQ4]
		fin && at_end && cur_c.ctl.loop && !s_r.a_wr
		|=> cur_c.ctl.en && cur_c.cur == cur_c.start)
		else $error("loop end did not keep running");
	path_rd_a: assert property ( // [RQ5]
		s_r.sb.rd |-> s_r.sb.addr == addr_of(cur_c, s_r.idx, cur_c.ctl.dir))
		else $error("read from wrong side");
	end_irq_a: assert property ( // [RQ6]
		fin && at_end && cur_c.ctl.completion_interrupt_enable && s_r.msk[s_r.act]
		|=> s_r.sts[s_r.act] ##0 irq)
		else $error("end transfer raised no interrupt");
	irq_quiet_a: assert property ( // [RQ6]
		fin && at_end && !cur_c.ctl.completion_interrupt_enable && !s_r.sts[s_r.act] |=> !s_r.sts[s_r.act])
		else $error("interrupt flag set while disabled");
	byte_once_a: assert property ( // [RQ7]
		s_r.sb.rd && !cur_c.ctl.word |-> ##2 !s_r.sb.rd && !s_r.sb.req)
		else $error("byte mode read twice");
	word_twice_a: assert property ( // [RQ8]
		s_r.fsm == dma_pkg::ST_WR && cur_c.ctl.word && !s_r.idx
		|=> s_r.sb.rd && s_r.sb.req && s_r.idx)
		else $error("word mode ended after one byte");
	bus_owned_a: assert property ( // [RQ14]
		(s_r.sb.rd || s_r.sb.wr) |-> s_r.sb.req ##0 (s_r.fsm != dma_pkg::ST_IDLE))
		else $error("bus used without request");
	req_hold_a: assert property ( // [RQ14]
		s_r.fsm == dma_pkg::ST_REQ && !sbus_ack |=> s_r.sb.req && !s_r.sb.rd)
		else $error("bus touched before acknowledge");
	advance_a: assert property ( // [RQ15]
		fin && !at_end && !s_r.a_wr
		|=> cur_c.cur == 12'($past(cur_c.cur) + ($past(cur_c.ctl.word) ?
			dma_pkg::WORD_STEP : dma_pkg::BYTE_STEP)))
		else $error("address did not advance by step");
	periph_page_a: assert property ( // [RQ17]
		s_r.sb.wr && !cur_c.ctl.dir |-> s_r.sb.addr[11:8] == dma_pkg::PERIPH_PAGE)
		else $error("peripheral write off page");

	// Main scenarios seen
	loop_wrap_c: cover property (fin && at_end && cur_c.ctl.loop);
	byte_end_c:  cover property (fin && at_end && !cur_c.ctl.loop && !cur_c.ctl.word);
	word_move_c: cover property (fin && cur_c.ctl.word);
	irq_rise_c:  cover property ($rose(irq));
	both_pend_c: cover property (s_r.ch[0].pend && s_r.ch[1].pend);

endmodule // dma_ctrl

`default_nettype wire

// ===== tb/sbus_model.sv
`timescale 1ns/1ns
`default_nettype none

module sbus_model (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire dma_pkg::sbus_out_t sbus,
	input  wire logic [3:0]         ack_dly,
	output logic                    sbus_ack,
	output logic [7:0]              sbus_rdata
);
	// Register file and peripheral page, one byte per address
	logic [7:0] mem [0:4095];
	// Cycles spent waiting for the grant
	logic [3:0] wait_cnt;
	// Filler on the data lines while no read stands
	logic [7:0] junk;

	// Read data answers the strobe within its own cycle
	assign sbus_rdata = sbus.rd ? mem[sbus.addr] : junk;

	// Known fill pattern
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = i[7:0] ^ 8'hA5;
	end

	// Grant, filler update and write capture
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wait_cnt   <= 4'h0;
			sbus_ack   <= 1'b0;
			junk       <= 8'h00;
		end
		else
		begin
			// Grant after a programmable delay, drop it on release
			if (sbus.req && !sbus_ack)
			begin
				if (wait_cnt >= ack_dly)
					sbus_ack <= 1'b1;
				wait_cnt <= wait_cnt + 4'h1;
			end
			else if (!sbus.req)
			begin
				sbus_ack <= 1'b0;
				wait_cnt <= 4'h0;
			end
			// Filler keeps changing so a stale sample shows up
			junk <= ~junk ^ 8'h3C;
			if (sbus.wr)
				mem[sbus.addr] <= sbus.wdata;
		end
	end
endmodule // sbus_model

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	// Bus and trigger stimulus
	logic               hclk = 1'b0;
	logic               hresetn = 1'b0;
	logic               hsel = 1'b0;
	logic [31:0]        haddr = '0;
	logic [1:0]         htrans = '0;
	logic               hwrite = 1'b0;
	logic [2:0]         hsize = 3'h2;
	logic [31:0]        hwdata = '0;
	logic [1:0][6:0]    trig = '0;
	logic [3:0]         ack_dly = 4'h0;
	// Design and bus model outputs
	logic               hreadyout;
	logic               hresp;
	logic               irq;
	logic               sbus_ack;
	logic [31:0]        hrdata;
	logic [7:0]         sbus_rdata;
	dma_pkg::sbus_out_t sbus;
	// Bookkeeping
	int                 err_count = 0;
	int                 total_checks = 0;
	logic [31:0]        q;
	logic [7:0]         prev;

	always #4 hclk = ~hclk;

	dma_ctrl i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .trig,
		.sbus_ack, .sbus_rdata, .sbus, .irq);

	sbus_model i_bus (.hclk, .hresetn, .sbus, .ack_dly, .sbus_ack, .sbus_rdata);

	// Expected fill pattern of the memory model
	function automatic logic [7:0] ev(input logic [11:0] a);
		return a[7:0] ^ 8'hA5;
	endfunction

	// Compare and count
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	// One AHB single transfer, entered just after a rising edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic rdy;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {20'h0, a};
		do
		begin
			@(negedge hclk) rdy = hreadyout;
			@(posedge hclk);
		end while (!rdy);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do
		begin
			@(negedge hclk) rdy = hreadyout;
			q = hrdata;
			@(posedge hclk);
		end while (!rdy);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, '0);
		chk($sformatf("reg %h", a), q, e);
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask

	task automatic mc(input logic [11:0] a, input logic [7:0] e);
		chk($sformatf("mem %h", a), {24'h0, i_bus.mem[a]}, {24'h0, e});
	endtask

	task automatic irqchk(input logic e);
		repeat (2) @(negedge hclk);
		chk("irq", {31'h0, irq}, {31'h0, e});
		@(posedge hclk);
	endtask

	// Raw source pulse; no central interrupt enable exists here
	task automatic pulse(input int ch, input logic [6:0] m);
		trig[ch] <= m;
		@(posedge hclk);
		trig <= '0;
		@(posedge hclk);
	endtask

	// Wait for a bus tenure to start and finish, bounded
	task automatic done();
		for (int n = 0; n < 20 && !sbus.req; n++)
			@(negedge hclk);
		for (int n = 0; n < 60 && sbus.req; n++)
			@(negedge hclk);
		chk("bus released", {31'h0, sbus.req}, 32'h0);
		@(posedge hclk);
	endtask

	task automatic fire(input int ch, input logic [6:0] m);
		pulse(ch, m);
		done();
	endtask

	task automatic conclude();
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		#200000;
		err_count++;
		conclude();
	end

	// Test sequence
	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(dma_pkg::CTL0_ADDR, 32'h0);
		rc(dma_pkg::CTL1_ADDR, 32'h0);
		rc(12'hFF0, 32'h0);
		// Single pass, byte, to peripheral, interrupt on end
		wr(dma_pkg::IO0_ADDR, 32'h40);
		wr(dma_pkg::SA0_ADDR, 32'h100);
		wr(dma_pkg::EA0_ADDR, 32'h101);
		wr(dma_pkg::MSK_ADDR, 32'h0);
		wr(dma_pkg::CTL0_ADDR, 32'h90);
		fire(0, 7'h01);
		mc(12'hF40, ev(12'h100));
		mc(12'hF41, ev(12'hF41));
		rc(dma_pkg::SA0_ADDR, 32'h0100_0101);
		fire(0, 7'h01);
		mc(12'hF40, ev(12'h101));
		rc(dma_pkg::SA0_ADDR, 32'h0100_0100);
		rc(dma_pkg::CTL0_ADDR, 32'h10);
		rc(dma_pkg::STS_ADDR, 32'h1);
		irqchk(1'b0);
		wr(dma_pkg::MSK_ADDR, 32'h1);
		irqchk(1'b1);
		wr(dma_pkg::STS_ADDR, 32'h1);
		irqchk(1'b0);
		fire(0, 7'h01);
		mc(12'hF40, ev(12'h101));
		// Loop, word, from peripheral; even peripheral address
		wr(dma_pkg::IO1_ADDR, 32'h50);
		wr(dma_pkg::SA1_ADDR, 32'h300);
		wr(dma_pkg::EA1_ADDR, 32'h302);
		wr(dma_pkg::CTL1_ADDR, 32'hEC);
		fire(1, 7'h10);
		fire(1, 7'h10);
		mc(12'h300, ev(12'hF50));
		mc(12'h303, ev(12'hF51));
		mc(12'h304, ev(12'h304));
		rc(dma_pkg::SA1_ADDR, 32'h0300_0300);
		rc(dma_pkg::CTL1_ADDR, 32'hEC);
		rc(dma_pkg::STS_ADDR, 32'h0);
		// Trigger codes zero to six, with a wrong source first
		wr(dma_pkg::IO0_ADDR, 32'h60);
		wr(dma_pkg::SA0_ADDR, 32'h200);
		wr(dma_pkg::EA0_ADDR, 32'h200);
		prev = ev(12'h200);
		for (int c = 0; c < 7; c++)
		begin
			i_bus.mem[12'hF60] = 8'h10 + c[7:0];
			wr(dma_pkg::CTL0_ADDR, 32'hE0 | c);
			fire(0, 7'h01 << ((c + 1) % 7));
			mc(12'h200, prev);
			fire(0, 7'h01 << c);
			prev = 8'h10 + c[7:0];
			mc(12'h200, prev);
		end
		// Reserved code reacts to nothing
		i_bus.mem[12'hF60] = 8'h77;
		wr(dma_pkg::CTL0_ADDR, 32'hE7);
		fire(0, 7'h7F);
		mc(12'h200, prev);
		// Triggers during a slow grant merge into one
		ack_dly <= 4'h6;
		wr(dma_pkg::SA0_ADDR, 32'h100);
		wr(dma_pkg::EA0_ADDR, 32'h1FF);
		wr(dma_pkg::CTL0_ADDR, 32'hC0);
		pulse(0, 7'h01);
		pulse(0, 7'h01);
		pulse(0, 7'h01);
		done();
		done();
		done();
		rc(dma_pkg::SA0_ADDR, 32'h0100_0102);
		conclude();
	end
endmodule // tb_top

`default_nettype wire
